// *** src/pdr_params.svh ***
// Behaviour
// - Capability register one high reads 0x1E; bits 1:0 give pull-up current.
// - Bit 4 of capability one high reports bleed discharge support.
// - Bit 3 reports forced discharge support.
// - Bit 2 reports bus voltage measurement and alarms.
// - Capability two low reads 0xD7; bits 7 and 6 report threshold registers.
// - Bits 5:4 report alarm resolution; 01b means 50 mV steps.
// - Bits 3:1 encode supported cable supply power level.
// - Bit 0 reports cable supply overcurrent detection ability.
// - Capability two high reads 0x01: watchdog present, bits 7:1 zero.
// - Standard output caps read 0x05: mux control and orientation present.
// - Message header register resets to 0x0B: plug origin, data and power role.
// - Header bits 2:1 select protocol revision placed in headers.
// - Receive enables bits 0 to 5 are writable, default zero.
// - Receive enable bits 7 and 6 always read zero.
// - Enabling a packet type also enables its automatic acknowledgement.
// - Receive enables clear on hard reset, one-more completion, disconnect, software reset, power-on.
// - All receive enables zero disables message handling.
// - Received byte count is payload bytes plus three.
// - Receive status bits 2:0 hold the stored packet type; bits 7:3 zero.
// - Received header bytes stored, reset zero; expected acknowledgements not stored.
// - Receive-one-more clears receive enables after the next acknowledgement sent.
`ifndef PDR_PARAMS_SVH
`define PDR_PARAMS_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define PDR_ADDR_CAP1H   8'h25
`define PDR_ADDR_CAP2L   8'h26
`define PDR_ADDR_CAP2H   8'h27
`define PDR_ADDR_STDOUT  8'h29
`define PDR_ADDR_MSGHDR  8'h2E
`define PDR_ADDR_RXDET   8'h2F
`define PDR_ADDR_RXCNT   8'h30
`define PDR_ADDR_RECEIVED_MESSAGE_STATUS  8'h31
`define PDR_ADDR_RXHDRL  8'h32
`define PDR_ADDR_RXHDRH  8'h33
// ----------------------------------------
// Fixed values, reset values and masks
// ----------------------------------------
`define PDR_CAP1H_VAL    8'h1E
`define PDR_CAP2L_VAL    8'hD7
`define PDR_CAP2H_VAL    8'h01
`define PDR_STDOUT_VAL   8'h05
`define PDR_MSGHDR_RST   8'h0B
`define PDR_MSGHDR_WMASK 8'h1F
`define PDR_RXDET_RST    8'h00
`define PDR_RXDET_WMASK  8'h3F
`define PDR_RXCNT_EXTRA  8'h03
`define PDR_RXTYPE_MASK  8'h07
`define PDR_RXDET_HRST   5
`define PDR_RX_RST       8'h00
`define PDR_RD_RST       8'h00
`define PDR_SOP_TYPES    3'd5
`endif

// *** src/pdr_pkg.sv ***
package pdr_pkg;
	typedef enum logic [1:0]
	{
		PDR_IDLE  = 2'b01,
		PDR_ARMED = 2'b10
	} pdr_omore_state_type;

	typedef struct packed
	{
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pdr_reg_req_type;

	typedef struct packed
	{
		logic        valid;
		logic        goodcrc;
		logic [2:0]  sop;
		logic [7:0]  payload_len;
		logic [15:0] header;
	} pdr_rx_msg_type;

	typedef struct packed
	{
		logic hard_reset_sent;
		logic hard_reset_rcvd;
		logic goodcrc_sent;
		logic disconnect;
		logic software_reset;
		logic receive_one_more_command;
	} pdr_event_type;
endpackage

// *** src/pdr_regs.sv ***
`timescale 1ns/100ps
`include "pdr_params.svh"

module pdr_regs #(
	parameter int PAYLOAD_MAX = 28
) (
	input  wire logic                     ref_clk_in,
	input  wire logic                     rst_in,
	input  wire pdr_pkg::pdr_reg_req_type reg_req_in,
	input  wire pdr_pkg::pdr_rx_msg_type  rx_msg_in,
	input  wire pdr_pkg::pdr_event_type   event_in,
	output logic [7:0]                    rd_data_out,
	output logic [5:0]                    detect_enable_out,
	output logic [4:0]                    goodcrc_enable_out,
	output logic                          pd_enable_out,
	output logic [4:0]                    msg_header_cfg_out
);
	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	// Count is eight bits wide including the three overhead bytes
	if (PAYLOAD_MAX < 1 || PAYLOAD_MAX > 252)
	begin : g_bad_payload
		$error("PAYLOAD_MAX out of range");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]                  msg_hdr_r;
	logic [7:0]                  rx_det_r;
	logic [7:0]                  rx_det_nxt;
	logic [7:0]                  rx_cnt_r;
	logic [7:0]                  rx_stat_r;
	logic [7:0]                  rx_hdrl_r;
	logic [7:0]                  rx_hdrh_r;
	logic [7:0]                  rd_data_r;
	logic [7:0]                  rd_data_nxt;
	logic                        pd_en_r;
	logic [4:0]                  crc_en_r;
	logic                        det_clear;
	logic                        type_enabled;
	logic                        store_msg;
	logic                        wr_msghdr;
	logic                        wr_rxdet;
	logic                        rd_mapped;
	pdr_pkg::pdr_omore_state_type omore_r;

	assign rd_data_out        = rd_data_r;
	assign detect_enable_out  = rx_det_r[5:0];
	assign goodcrc_enable_out = crc_en_r;
	assign pd_enable_out      = pd_en_r;
	assign msg_header_cfg_out = msg_hdr_r[4:0];

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	assign wr_msghdr = reg_req_in.wr && reg_req_in.addr == `PDR_ADDR_MSGHDR;
	assign wr_rxdet  = reg_req_in.wr && reg_req_in.addr == `PDR_ADDR_RXDET;
	// Only the checks use this; the read mux keeps its own default
	assign rd_mapped = reg_req_in.addr inside {`PDR_ADDR_CAP1H, `PDR_ADDR_CAP2L, `PDR_ADDR_CAP2H,
		`PDR_ADDR_STDOUT, `PDR_ADDR_MSGHDR, `PDR_ADDR_RXDET, `PDR_ADDR_RXCNT, `PDR_ADDR_RECEIVED_MESSAGE_STATUS,
		`PDR_ADDR_RXHDRL, `PDR_ADDR_RXHDRH};

	// ----------------------------------------
	// Receive-one-more tracking
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			omore_r <= pdr_pkg::PDR_IDLE;
		else
		begin
			unique case (omore_r)
				pdr_pkg::PDR_IDLE:
					if (event_in.receive_one_more_command)
						omore_r <= pdr_pkg::PDR_ARMED;
				pdr_pkg::PDR_ARMED:
					// A fresh command in the completing cycle re-arms
					if (event_in.goodcrc_sent && !event_in.receive_one_more_command)
						omore_r <= pdr_pkg::PDR_IDLE;
				default:
					omore_r <= pdr_pkg::PDR_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Receive enables
	// ----------------------------------------
	// Clearing beats a same-cycle write so the manager cannot revive reception past a reset
	assign det_clear = event_in.hard_reset_sent | event_in.hard_reset_rcvd | event_in.disconnect
		| event_in.software_reset
		| ((omore_r == pdr_pkg::PDR_ARMED) & event_in.goodcrc_sent);

	always_comb
	begin
		rx_det_nxt = rx_det_r;
		if (det_clear)
			rx_det_nxt = `PDR_RXDET_RST;
		else if (wr_rxdet)
			rx_det_nxt = reg_req_in.wdata & `PDR_RXDET_WMASK;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_det_r <= `PDR_RXDET_RST;
			pd_en_r  <= 1'b0;
			crc_en_r <= 5'h00;
		end
		else
		begin
			rx_det_r <= rx_det_nxt;
			pd_en_r  <= |rx_det_nxt;
			crc_en_r <= rx_det_nxt[4:0];
		end
	end

	// ----------------------------------------
	// Message header configuration
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			msg_hdr_r <= `PDR_MSGHDR_RST;
		else if (event_in.software_reset)
			msg_hdr_r <= `PDR_MSGHDR_RST;
		else if (wr_msghdr)
			msg_hdr_r <= reg_req_in.wdata & `PDR_MSGHDR_WMASK;
	end

	// ----------------------------------------
	// Received message capture
	// ----------------------------------------
	// Cable reset code has no enable bit, so it is never captured
	assign type_enabled = (rx_msg_in.sop < `PDR_SOP_TYPES) && rx_det_r[rx_msg_in.sop];
	assign store_msg    = rx_msg_in.valid && !rx_msg_in.goodcrc && type_enabled
		&& (rx_msg_in.payload_len <= 8'(PAYLOAD_MAX));

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_cnt_r  <= `PDR_RX_RST;
			rx_stat_r <= `PDR_RX_RST;
			rx_hdrl_r <= `PDR_RX_RST;
			rx_hdrh_r <= `PDR_RX_RST;
		end
		else if (store_msg)
		begin
			rx_cnt_r  <= 8'(rx_msg_in.payload_len + `PDR_RXCNT_EXTRA);
			rx_stat_r <= {5'h00, rx_msg_in.sop};
			rx_hdrl_r <= rx_msg_in.header[7:0];
			rx_hdrh_r <= rx_msg_in.header[15:8];
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_comb
	begin
		rd_data_nxt = 8'h00;
		unique case (reg_req_in.addr)
			`PDR_ADDR_CAP1H:  rd_data_nxt = `PDR_CAP1H_VAL;
			`PDR_ADDR_CAP2L:  rd_data_nxt = `PDR_CAP2L_VAL;
			`PDR_ADDR_CAP2H:  rd_data_nxt = `PDR_CAP2H_VAL;
			`PDR_ADDR_STDOUT: rd_data_nxt = `PDR_STDOUT_VAL;
			`PDR_ADDR_MSGHDR: rd_data_nxt = msg_hdr_r;
			`PDR_ADDR_RXDET:  rd_data_nxt = rx_det_r;
			`PDR_ADDR_RXCNT:  rd_data_nxt = rx_cnt_r;
			`PDR_ADDR_RECEIVED_MESSAGE_STATUS: rd_data_nxt = rx_stat_r;
			`PDR_ADDR_RXHDRL: rd_data_nxt = rx_hdrl_r;
			`PDR_ADDR_RXHDRH: rd_data_nxt = rx_hdrh_r;
			default:          rd_data_nxt = 8'h00;
		endcase
	end

	// Data holds between reads so a slow serial front end can shift it out
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			rd_data_r <= `PDR_RD_RST;
		else if (reg_req_in.rd)
			rd_data_r <= rd_data_nxt;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	cap1h_read_a: assert property (
		reg_req_in.rd && reg_req_in.addr == `PDR_ADDR_CAP1H |=> rd_data_out == 8'h1E)
		else $error("cap one high value wrong");

	cap2l_read_a: assert property (
		reg_req_in.rd && reg_req_in.addr == `PDR_ADDR_CAP2L |=> rd_data_out == 8'hD7)
		else $error("cap two low value wrong");

	cap2h_read_a: assert property (
		reg_req_in.rd && reg_req_in.addr == `PDR_ADDR_CAP2H |=> rd_data_out == 8'h01)
		else $error("cap two high value wrong");

	stdout_read_a: assert property (
		reg_req_in.rd && reg_req_in.addr == `PDR_ADDR_STDOUT |=> rd_data_out == 8'h05)
		else $error("standard output caps wrong");

	msghdr_mask_a: assert property (
		reg_req_in.wr && reg_req_in.addr == `PDR_ADDR_MSGHDR && !event_in.software_reset
		|=> msg_hdr_r == ($past(reg_req_in.wdata) & 8'h1F))
		else $error("message header write wrong");

	rxdet_reserved_a: assert property (
		rx_det_r[7:6] == 2'b00)
		else $error("reserved enable bits set");

	rxdet_clear_a: assert property (
		event_in.hard_reset_rcvd || event_in.disconnect |=> rx_det_r == 8'h00 && !pd_enable_out)
		else $error("enables not cleared");

	pd_disable_a: assert property (
		reg_req_in.wr && reg_req_in.addr == `PDR_ADDR_RXDET && reg_req_in.wdata == 8'h00
		|=> !pd_enable_out && goodcrc_enable_out == 5'h00)
		else $error("message handling still on");

	crc_follow_a: assert property (
		goodcrc_enable_out == detect_enable_out[4:0])
		else $error("acknowledge enables differ");

	byte_count_a: assert property (
		store_msg |=> rx_cnt_r == $past(rx_msg_in.payload_len) + 8'h03 && rx_stat_r[7:3] == 5'h00)
		else $error("byte count wrong");

	goodcrc_skip_a: assert property (
		rx_msg_in.valid && rx_msg_in.goodcrc |=> $stable(rx_hdrl_r) && $stable(rx_hdrh_r))
		else $error("acknowledge header stored");

	one_more_a: assert property (
		event_in.receive_one_more_command ##1 (!event_in.goodcrc_sent && !reg_req_in.wr)[*2]
		##1 event_in.goodcrc_sent |=> rx_det_r == 8'h00)
		else $error("one-more did not clear enables");

	// ----------------------------------------
	// Checks: receive enables
	// ----------------------------------------
	rxdet_write_a: assert property (
		wr_rxdet && !det_clear |=> rx_det_r == ($past(reg_req_in.wdata) & `PDR_RXDET_WMASK))
		else $error("enable write not stored");

	rxdet_hold_a: assert property (
		!wr_rxdet && !det_clear |=> $stable(rx_det_r))
		else $error("enables changed without cause");

	rxdet_sent_a: assert property (
		event_in.hard_reset_sent || event_in.software_reset |=> rx_det_r == `PDR_RXDET_RST && !pd_enable_out)
		else $error("enables not cleared by reset event");

	crc_write_a: assert property (
		wr_rxdet && !det_clear |=> goodcrc_enable_out == $past(reg_req_in.wdata[4:0]))
		else $error("acknowledge enables not written");

	pd_write_a: assert property (
		wr_rxdet && !det_clear && (reg_req_in.wdata & `PDR_RXDET_WMASK) != 8'h00
		|=> pd_enable_out)
		else $error("message handling not enabled");

	rxdet_read_a: assert property (
		reg_req_in.rd && reg_req_in.addr == `PDR_ADDR_RXDET |=> rd_data_out == $past(rx_det_r))
		else $error("enable readback wrong");

	// ----------------------------------------
	// Checks: message header
	// ----------------------------------------
	msghdr_reserved_a: assert property (
		msg_hdr_r[7:5] == 3'h0)
		else $error("header reserved bits set");

	msghdr_swrst_a: assert property (
		event_in.software_reset |=> msg_hdr_r == `PDR_MSGHDR_RST)
		else $error("header not reloaded");

	msghdr_hold_a: assert property (
		!wr_msghdr && !event_in.software_reset |=> $stable(msg_hdr_r))
		else $error("header changed without write");

	// ----------------------------------------
	// Checks: received message capture
	// ----------------------------------------
	stat_type_a: assert property (
		store_msg |=> rx_stat_r[2:0] == $past(rx_msg_in.sop))
		else $error("stored packet type wrong");

	received_message_status_reserved_a: assert property (
		rx_stat_r[7:3] == 5'h00)
		else $error("status reserved bits set");

	header_store_a: assert property (
		store_msg |=> {rx_hdrh_r, rx_hdrl_r} == $past(rx_msg_in.header))
		else $error("header bytes wrong");

	disabled_drop_a: assert property (
		rx_msg_in.valid && rx_msg_in.sop < `PDR_SOP_TYPES && !rx_det_r[rx_msg_in.sop]
		|=> $stable(rx_cnt_r) && $stable(rx_hdrl_r))
		else $error("disabled type stored");

	cable_reset_skip_a: assert property (
		rx_msg_in.valid && rx_msg_in.sop >= `PDR_SOP_TYPES |=> $stable(rx_stat_r) && $stable(rx_cnt_r))
		else $error("undetectable type stored");

	oversize_drop_a: assert property (
		rx_msg_in.valid && rx_msg_in.payload_len > 8'(PAYLOAD_MAX) |=> $stable(rx_cnt_r) && $stable(rx_hdrh_r))
		else $error("oversize message stored");

	rx_hold_a: assert property (
		!store_msg |=> $stable(rx_cnt_r) && $stable(rx_stat_r) && $stable(rx_hdrl_r) && $stable(rx_hdrh_r))
		else $error("receive registers changed");

	// ----------------------------------------
	// Checks: read port and one-more tracking
	// ----------------------------------------
	rd_hold_a: assert property (
		!reg_req_in.rd |=> $stable(rd_data_out))
		else $error("read data changed without read");

	unmapped_read_a: assert property (
		reg_req_in.rd && !rd_mapped |=> rd_data_out == 8'h00)
		else $error("unmapped read not zero");

	omore_arm_a: assert property (
		event_in.receive_one_more_command |=> omore_r == pdr_pkg::PDR_ARMED)
		else $error("one-more not armed");

	omore_done_a: assert property (
		omore_r == pdr_pkg::PDR_ARMED && event_in.goodcrc_sent && !event_in.receive_one_more_command
		|=> omore_r == pdr_pkg::PDR_IDLE)
		else $error("one-more not released");

	omore_onehot_a: assert property (
		$onehot(omore_r))
		else $error("one-more state illegal");
endmodule

// *** bench/pdr_mgr_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Port manager model on the register port
// ----------------------------------------
module pdr_mgr_model (
	input  wire logic                ref_clk_in,
	output pdr_pkg::pdr_reg_req_type req_out
);
	initial req_out = '0;
	// One request held over one edge, then released with strobes low and address and data inverted
	// so a design that samples a stale bus sees garbage, not a lucky match
	task automatic access(input logic rd, input logic wr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge ref_clk_in);
		#1;
		req_out = '{rd: rd, wr: wr, addr: addr, wdata: data};
		@(posedge ref_clk_in);
		#1;
		req_out = '{rd: 1'h0, wr: 1'h0, addr: ~addr, wdata: ~data};
	endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
	logic                     ref_clk_in;
	logic                     rst_in;
	pdr_pkg::pdr_reg_req_type reg_req;
	pdr_pkg::pdr_rx_msg_type  rx_msg;
	pdr_pkg::pdr_event_type   evt;
	logic [7:0]               rd_data;
	logic [5:0]               det_en;
	logic [4:0]               crc_en;
	logic                     pd_en;
	logic [4:0]               hdr_cfg;
	logic                     rd_seen;
	logic [15:0]              exp_q[$];
	logic [15:0]              e;
	logic [7:0]               len;
	logic [7:0]               v;
	logic [15:0]              hdr;
	int                       miscompares;
	int                       compares;
	logic [7:0]               addrs[10] = '{8'h25, 8'h26, 8'h27, 8'h29, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33};
	logic [7:0]               rsts[10] = '{8'h1E, 8'hD7, 8'h01, 8'h05, 8'h0B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	pdr_mgr_model mgr_u (.ref_clk_in(ref_clk_in), .req_out(reg_req));
	pdr_regs #(.PAYLOAD_MAX(28)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_req_in(reg_req),
		.rx_msg_in(rx_msg), .event_in(evt), .rd_data_out(rd_data), .detect_enable_out(det_en),
		.goodcrc_enable_out(crc_en), .pd_enable_out(pd_en), .msg_header_cfg_out(hdr_cfg));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		exp_q.push_back({a, x});
		mgr_u.access(1'h1, 1'h0, a, 8'h00);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		mgr_u.access(1'h0, 1'h1, a, d);
	endtask
	task automatic send(input logic g, input logic [2:0] s, input logic [7:0] l, input logic [15:0] h);
		@(posedge ref_clk_in);
		#1;
		rx_msg = '{valid: 1'h1, goodcrc: g, sop: s, payload_len: l, header: h};
		@(posedge ref_clk_in);
		#1;
		rx_msg.valid = 1'h0;
	endtask
	task automatic pulse(input logic [5:0] p);
		@(posedge ref_clk_in);
		#1;
		evt = p;
		@(posedge ref_clk_in);
		#1;
		evt = '0;
	endtask

	// ----------------------------------------
	// Read watcher: data stands from the edge after the read strobe
	// ----------------------------------------
	always @(posedge ref_clk_in) rd_seen <= reg_req.rd;
	always @(negedge ref_clk_in)
		if (rd_seen === 1'h1)
		begin
			e = exp_q.size() ? exp_q.pop_front() : 16'hFFFF;
			check($sformatf("read %0h", e[15:8]), rd_data, e[7:0]);
		end

	initial
	begin
		ref_clk_in = 1'h0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk_in);
		miscompares++;
		finish_test();
	end

	initial
	begin
		rst_in = 1'h1;
		rx_msg = '0;
		evt = '0;
		void'($urandom(28));
		repeat (12) @(posedge ref_clk_in);
		#1;
		rst_in = 1'h0;
		for (int i = 0; i < 10; i++) rd(addrs[i], rsts[i]);
		rd(8'h28, 8'h00);
		// Ones everywhere: only writable fields may keep them
		for (int i = 0; i < 10; i++) wr(addrs[i], 8'hFF);
		for (int i = 0; i < 10; i++) rd(addrs[i], i == 4 ? 8'h1F : i == 5 ? 8'h3F : rsts[i]);
		check("enables", {det_en, crc_en, pd_en}, {6'h3F, 5'h1F, 1'h1});
		for (int r = 0; r < 4; r++)
		begin
			v = 8'($urandom);
			v[2:1] = 2'(r);
			wr(8'h2E, v);
			check("header cfg", hdr_cfg, v[4:0]);
			rd(8'h2E, v & 8'h1F);
		end
		wr(8'h2F, 8'h00);
		check("pd off", {det_en, pd_en}, 7'h00);
		// Receive every start-of-packet type, longest payload last
		wr(8'h2F, 8'h1F);
		for (int s = 0; s < 5; s++)
		begin
			len = s == 4 ? 8'h1C : 8'($urandom_range(27, 0));
			hdr = 16'($urandom);
			send(1'h0, 3'(s), len, hdr);
			rd(8'h30, len + 8'h03);
			rd(8'h31, 8'(s));
			rd(8'h32, hdr[7:0]);
			rd(8'h33, hdr[15:8]);
		end
		send(1'h1, 3'h0, 8'h02, ~hdr); // acknowledgement is not stored
		wr(8'h2F, 8'h01);
		send(1'h0, 3'h1, 8'h02, ~hdr); // disabled type is dropped
		rd(8'h32, hdr[7:0]);
		rd(8'h31, 8'h04);
		send(1'h0, 3'h0, 8'h1D, ~hdr); // oversize payload is dropped
		send(1'h0, 3'h6, 8'h02, ~hdr); // cable reset type is never stored
		rd(8'h30, 8'h1F);
		rd(8'h31, 8'h04);
		// Clear events
		for (int k = 1; k < 6; k++)
		begin
			if (k == 3)
				continue;
			wr(8'h2F, 8'h3F);
			wr(8'h2E, 8'h00);
			pulse(6'(1 << k));
			check("cleared", det_en, 6'h00);
			if (k == 1)
				check("sw reset header", hdr_cfg, 5'h0B);
		end
		wr(8'h2F, 8'h3F);
		pulse(6'h08);
		check("unarmed ack", det_en, 6'h3F);
		pulse(6'h01);
		@(posedge ref_clk_in);
		#1;
		check("armed", det_en, 6'h3F);
		pulse(6'h08);
		check("one more", {det_en, pd_en}, 7'h00);
		// Power-on clear in mid-run
		wr(8'h2F, 8'h3F);
		wr(8'h2E, 8'h00);
		rst_in = 1'h1;
		repeat (2) @(posedge ref_clk_in);
		#1;
		rst_in = 1'h0;
		check("power-on enables", {det_en, crc_en, pd_en}, 12'h000);
		check("power-on header", hdr_cfg, 5'h0B);
		rd(8'h2F, 8'h00);
		rd(8'h33, 8'h00);
		repeat (3) @(posedge ref_clk_in);
		check("reads left", 16'(exp_q.size()), 16'h0000);
		finish_test();
	end
endmodule
